// ### design/aei_pkg.sv
package aei_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int AXES   = 3;
  localparam int ACC_W  = 14;
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_LOW_TH    = 8'h01;
  localparam logic [7:0] OFS_LOW_DUR   = 8'h02;
  localparam logic [7:0] OFS_LOW_HYST  = 8'h03;
  localparam logic [7:0] OFS_HIGH_TH   = 8'h04;
  localparam logic [7:0] OFS_HIGH_DUR  = 8'h05;
  localparam logic [7:0] OFS_HIGH_HYST = 8'h06;
  localparam logic [7:0] OFS_SLOPE_TH  = 8'h07;
  localparam logic [7:0] OFS_TAP_WIN   = 8'h08;
  localparam logic [7:0] OFS_TEMP_OFS  = 8'h09;
  localparam logic [7:0] OFS_TEMP      = 8'h0A;
  localparam logic [7:0] OFS_STATUS    = 8'h0B;
  localparam logic [7:0] OFS_MASK      = 8'h0C;
  localparam logic [7:0] OFS_LEVEL     = 8'h0D;
  localparam logic [7:0] OFS_ACC_BASE  = 8'h0E;
  localparam logic [7:0] OFS_ACC_LAST  = 8'h13;

  // ----------------------------------------------------------------
  // Control bit positions
  // ----------------------------------------------------------------
  localparam int CB_LOW_EN   = 0;
  localparam int CB_HIGH_EN  = 1;
  localparam int CB_SLOPE_EN = 2;
  localparam int CB_TAP_EN   = 3;
  localparam int CB_DRDY_EN  = 4;
  localparam int CB_ALERT    = 5;
  localparam int CB_LATCH    = 6;
  localparam int CB_INT_RST  = 7;

  // Status and mask bit positions
  localparam int SB_LOW   = 0;
  localparam int SB_HIGH  = 1;
  localparam int SB_SLOPE = 2;
  localparam int SB_TAP   = 3;
  localparam int SB_DRDY  = 4;
  localparam int SB_W     = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_TH    = 8'h00;
  localparam logic [7:0] RST_MASK  = 8'h00;
  localparam logic [7:0] RST_DUR   = 8'h01;
  localparam logic [7:0] RST_WIN   = 8'h10;
  // Thresholds are scaled up by this shift to meet the sample magnitude
  localparam int TH_SHIFT = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [AXES-1:0][ACC_W-1:0] axis;
  } aei_sample_s;

  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } aei_bus_s;

  typedef enum logic [1:0] {
    TAP_IDLE = 2'b00,
    TAP_WAIT = 2'b01,
    TAP_HOLD = 2'b10
  } aei_tap_e;

endpackage

// ### design/aei_axis.sv
`timescale 1ns/100ps
module aei_axis
  import aei_pkg::*;
#(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Sample
  input  wire logic         valid,
  input  wire logic [W-1:0] sample,
  // Derived values
  output logic      [W-1:0] mag,
  output logic      [W:0]   slope
);
  logic [W-1:0] prev;
  logic [W:0]   diff;

  // Magnitude of a two's complement sample
  assign mag  = sample[W-1] ? W'(~sample + 1'b1) : sample;
  // One extra bit so the difference of two signed samples never wraps
  assign diff = {sample[W-1], sample} - {prev[W-1], prev};
  assign slope = diff[W] ? (W+1)'(~diff + 1'b1) : diff;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= '0;
    end else if (valid) begin
      prev <= sample;
    end
  end
endmodule

// ### design/aei_dur.sv
`timescale 1ns/100ps
module aei_dur
  import aei_pkg::*;
#(
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Settings
  input  wire logic          en,
  input  wire logic          latch,
  input  wire logic [DW-1:0] dur,
  // Per-sample conditions
  input  wire logic          valid,
  input  wire logic          cond,
  input  wire logic          early,
  input  wire logic          release_c,
  input  wire logic          clr,
  // Result
  output logic               active
);
  logic [DW-1:0] cnt;
  logic          run;

  // Alert mode lets motion start the countdown before the condition
  assign run = cond | early;

  always_ff @(posedge clk) begin
    if (rst || !en) begin
      cnt <= dur;
    end else if (valid) begin
      if (!run) begin
        cnt <= dur;
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !en) begin
      active <= 1'b0;
    end else if (active) begin
      if (latch ? clr : (valid && release_c)) begin
        active <= 1'b0;
      end
    end else if (valid && cond && (cnt <= DW'(1) || dur == '0)) begin
      active <= 1'b1;
    end
  end
endmodule

// ### design/aei_top.sv
// Behaviour
// - Each temperature result is shown in an 8-bit register, shifted by a software offset.
// - The interrupt output rises on an enabled event whether or not the bus is busy.
// - Low-g is present only when the magnitude of every axis is below the low threshold.
// - The low-g interrupt rises only after low-g has held for a programmed number of samples.
// - A control bit enables low-g; it loads from the EEPROM image and a write changes it at once.
// - Low-g clears on master reset in latched mode, else when any axis leaves it by the hysteresis.
// - High-g has its own threshold, enable, duration and reset behaviour like low-g.
// - High-g and low-g interrupt conditions are ORed onto the interrupt output.
// - Any-motion raises an event when the sample-to-sample change passes a threshold.
// - Tap raises an interrupt when two slope events fall within a bounded window.
// - Alert mode lets motion start the low-g and high-g duration countdowns early.
// - Control and mask bits choose which sources drive the interrupt and how.
// - With data-ready enabled the interrupt rises after the last axis of each refresh.
// - Data-ready clears once the host has read the new acceleration data.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/100ps
module aei_top
#(
  parameter int DUR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Filtered samples, pulse after the last axis is converted
  input  wire logic              sample_valid,
  input  wire aei_pkg::aei_sample_s sample,
  // Temperature conversion
  input  wire logic              temp_valid,
  input  wire logic [7:0]        temp_raw,
  // Non-volatile image load
  input  wire logic              ee_load,
  input  wire logic [7:0]        ee_ctrl,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Interrupt
  output logic                   int_out
);
  import aei_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0]      ctrl;
  logic [7:0]      low_th;
  logic [7:0]      low_dur;
  logic [7:0]      low_hyst;
  logic [7:0]      high_th;
  logic [7:0]      high_dur;
  logic [7:0]      high_hyst;
  logic [7:0]      slope_th;
  logic [7:0]      tap_win;
  logic [7:0]      temp_ofs;
  logic [7:0]      temp_val;
  logic [SB_W-1:0] status;
  logic [SB_W-1:0] mask;
  aei_sample_s     acc_hold;

  aei_bus_s        bus;
  logic            int_clr;
  logic            wr_ctrl;
  logic            rd_status;
  logic            rd_acc_last;

  assign bus.addr  = reg_addr;
  assign bus.wdata = reg_wdata;
  assign bus.wr    = reg_wr;
  assign bus.rd    = reg_rd;

  assign wr_ctrl     = bus.wr && bus.addr == OFS_CTRL;
  // Master reset of latched interrupts is a self-clearing command bit
  assign int_clr     = wr_ctrl && bus.wdata[CB_INT_RST];
  assign rd_status   = bus.rd && bus.addr == OFS_STATUS;
  assign rd_acc_last = bus.rd && bus.addr == OFS_ACC_LAST;

  // ----------------------------------------------------------------
  // Control register and EEPROM image
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= {1'b0, bus.wdata[CB_INT_RST-1:0]};
    end else if (ee_load) begin
      ctrl <= {1'b0, ee_ctrl[CB_INT_RST-1:0]};
    end
  end

  // ----------------------------------------------------------------
  // Threshold, duration and window registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      low_th    <= RST_TH;
      low_dur   <= RST_DUR;
      low_hyst  <= RST_TH;
      high_th   <= RST_TH;
      high_dur  <= RST_DUR;
      high_hyst <= RST_TH;
      slope_th  <= RST_TH;
      tap_win   <= RST_WIN;
      temp_ofs  <= RST_TH;
      mask      <= RST_MASK[SB_W-1:0];
    end else if (bus.wr) begin
      case (bus.addr)
        OFS_LOW_TH:    low_th    <= bus.wdata;
        OFS_LOW_DUR:   low_dur   <= bus.wdata;
        OFS_LOW_HYST:  low_hyst  <= bus.wdata;
        OFS_HIGH_TH:   high_th   <= bus.wdata;
        OFS_HIGH_DUR:  high_dur  <= bus.wdata;
        OFS_HIGH_HYST: high_hyst <= bus.wdata;
        OFS_SLOPE_TH:  slope_th  <= bus.wdata;
        OFS_TAP_WIN:   tap_win   <= bus.wdata;
        OFS_TEMP_OFS:  temp_ofs  <= bus.wdata;
        OFS_MASK:      mask      <= bus.wdata[SB_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Temperature result
  // ----------------------------------------------------------------
  // Offset wraps modulo 256, software keeps the range it needs
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_val <= RST_TH;
    end else if (temp_valid) begin
      temp_val <= temp_raw + temp_ofs;
    end
  end

  // Copy of the last sample, replaced on every sample_valid even between bytes of a read
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_hold <= '0;
    end else if (sample_valid) begin
      acc_hold <= sample;
    end
  end

  // ----------------------------------------------------------------
  // Per-axis magnitude and slope
  // ----------------------------------------------------------------
  logic [AXES-1:0][ACC_W-1:0] mag;
  logic [AXES-1:0][ACC_W:0]   slope;
  logic [AXES-1:0]            ax_low;
  logic [AXES-1:0]            ax_low_out;
  logic [AXES-1:0]            ax_high;
  logic [AXES-1:0]            ax_high_out;
  logic [AXES-1:0]            ax_slope;

  logic [ACC_W-1:0] low_lim;
  logic [ACC_W-1:0] low_rel;
  logic [ACC_W-1:0] high_lim;
  logic [ACC_W-1:0] high_rel;
  logic [ACC_W:0]   slope_lim;
  logic [8:0]       low_sum;
  logic [8:0]       high_dif;

  assign low_sum   = {1'b0, low_th} + {1'b0, low_hyst};
  // Hysteresis larger than the high threshold saturates at zero
  assign high_dif  = (high_hyst > high_th) ? 9'h000 : {1'b0, high_th} - {1'b0, high_hyst};
  assign low_lim   = ACC_W'({low_th, TH_SHIFT'(0)});
  assign low_rel   = ACC_W'({low_sum, TH_SHIFT'(0)});
  assign high_lim  = ACC_W'({high_th, TH_SHIFT'(0)});
  assign high_rel  = ACC_W'({high_dif, TH_SHIFT'(0)});
  assign slope_lim = (ACC_W+1)'({slope_th, TH_SHIFT'(0)});

  for (genvar i = 0; i < AXES; i++) begin : g_axis
    aei_axis #(
      .W (ACC_W)
    ) u_axis (
      .clk (clk), .rst (rst), .valid (sample_valid),
      .sample (sample.axis[i]), .mag (mag[i]), .slope (slope[i])
    );
    assign ax_low[i]      = mag[i] < low_lim;
    assign ax_low_out[i]  = mag[i] >= low_rel;
    assign ax_high[i]     = mag[i] > high_lim;
    assign ax_high_out[i] = mag[i] < high_rel;
    assign ax_slope[i]    = slope[i] > slope_lim;
  end

  // ----------------------------------------------------------------
  // Global criteria
  // ----------------------------------------------------------------
  logic low_cond;
  logic low_release;
  logic high_cond;
  logic high_release;
  logic slope_cond;
  logic early;

  assign low_cond     = &ax_low;
  // Leaving low-g needs only one axis at or above threshold plus hysteresis
  assign low_release  = |ax_low_out;
  assign high_cond    = |ax_high;
  assign high_release = &ax_high_out;
  assign slope_cond   = ctrl[CB_SLOPE_EN] && (|ax_slope);
  assign early        = ctrl[CB_ALERT] && (|ax_slope);

  // ----------------------------------------------------------------
  // Duration and reset behaviour
  // ----------------------------------------------------------------
  logic low_active;
  logic high_active;

  aei_dur #(
    .DW (DUR_W)
  ) u_low (
    .clk (clk), .rst (rst), .latch (ctrl[CB_LATCH]), .dur (DUR_W'(low_dur)), .valid (sample_valid),
    .cond (low_cond), .early (early), .release_c (low_release), .clr (int_clr), .active (low_active),
    .en (ctrl[CB_LOW_EN])
  );
  aei_dur #(
    .DW (DUR_W)
  ) u_high (
    .clk (clk), .rst (rst), .latch (ctrl[CB_LATCH]), .dur (DUR_W'(high_dur)), .valid (sample_valid),
    .cond (high_cond), .early (early), .release_c (high_release), .clr (int_clr), .active (high_active),
    .en (ctrl[CB_HIGH_EN])
  );

  // ----------------------------------------------------------------
  // Slope event and double tap
  // ----------------------------------------------------------------
  logic       slope_prev;
  logic       slope_evt;
  logic       tap_evt;
  aei_tap_e   tap_st;
  logic [7:0] tap_cnt;

  // A slope event is the first sample of a burst over threshold
  assign slope_evt = sample_valid && slope_cond && !slope_prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      slope_prev <= 1'b0;
    end else if (sample_valid) begin
      slope_prev <= slope_cond;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !ctrl[CB_TAP_EN]) begin
      tap_st  <= TAP_IDLE;
      tap_cnt <= '0;
      tap_evt <= 1'b0;
    end else begin
      tap_evt <= 1'b0;
      case (tap_st)
        TAP_IDLE: begin
          if (slope_evt) begin
            tap_st  <= TAP_WAIT;
            tap_cnt <= tap_win;
          end
        end
        TAP_WAIT: begin
          if (slope_evt) begin
            tap_evt <= 1'b1;
            tap_st  <= TAP_HOLD;
          end else if (sample_valid) begin
            if (tap_cnt <= 8'h01) begin
              tap_st <= TAP_IDLE;
            end else begin
              tap_cnt <= tap_cnt - 8'h01;
            end
          end
        end
        // Third slope of a burst does not chain a second tap
        TAP_HOLD: begin
          if (sample_valid && !slope_cond) begin
            tap_st <= TAP_IDLE;
          end
        end
        default: tap_st <= TAP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sticky status, read clears, set wins
  // ----------------------------------------------------------------
  logic [SB_W-1:0] set_vec;
  logic [SB_W-1:0] next_status;

  assign set_vec[SB_LOW]   = low_active;
  assign set_vec[SB_HIGH]  = high_active;
  assign set_vec[SB_SLOPE] = slope_evt;
  assign set_vec[SB_TAP]   = tap_evt;
  assign set_vec[SB_DRDY]  = ctrl[CB_DRDY_EN] && sample_valid;

  always_comb begin
    next_status = status;
    if (rd_status) begin
      next_status = '0;
    end
    if (rd_acc_last) begin
      next_status[SB_DRDY] = 1'b0;
    end
    next_status = next_status | set_vec;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // Level output, independent of bus activity
  assign int_out = |(status & mask);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] acc_idx;
  logic [1:0] ax_sel;
  logic       hi_byte;

  assign acc_idx = bus.addr - OFS_ACC_BASE;
  assign ax_sel  = acc_idx[2:1];
  assign hi_byte = acc_idx[0];

  always_comb begin
    rd_mux = 8'h00;
    case (bus.addr)
      OFS_CTRL:      rd_mux = ctrl;
      OFS_LOW_TH:    rd_mux = low_th;
      OFS_LOW_DUR:   rd_mux = low_dur;
      OFS_LOW_HYST:  rd_mux = low_hyst;
      OFS_HIGH_TH:   rd_mux = high_th;
      OFS_HIGH_DUR:  rd_mux = high_dur;
      OFS_HIGH_HYST: rd_mux = high_hyst;
      OFS_SLOPE_TH:  rd_mux = slope_th;
      OFS_TAP_WIN:   rd_mux = tap_win;
      OFS_TEMP_OFS:  rd_mux = temp_ofs;
      OFS_TEMP:      rd_mux = temp_val;
      OFS_STATUS:    rd_mux = 8'(status);
      OFS_MASK:      rd_mux = 8'(mask);
      OFS_LEVEL:     rd_mux = {5'h00, slope_cond, high_active, low_active};
      default: begin
        if (bus.addr >= OFS_ACC_BASE && bus.addr <= OFS_ACC_LAST) begin
          // Little end first, upper two bits of the high byte read zero
          rd_mux = hi_byte ? 8'(acc_hold.axis[ax_sel][ACC_W-1:8])
                           : acc_hold.axis[ax_sel][7:0];
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (bus.rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule

// ### sim/aei_top_asserts.sv
`timescale 1ns/100ps
module aei_top_asserts
  import aei_pkg::*;
#(
  parameter int DUR_W = 8
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Events
  input wire logic       sample_valid,
  input wire logic       temp_valid,
  input wire logic [7:0] temp_raw,
  input wire logic       ee_load,
  input wire logic [7:0] ee_ctrl,
  // Register port and interrupt
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       int_out
);
  logic [7:0] ctrl_q, mask_q, ofs_q, temp_q;

  // Shadow of the settings the properties depend on
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= 8'h00;
      mask_q <= 8'h00;
      ofs_q  <= 8'h00;
      temp_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == OFS_CTRL) ctrl_q <= reg_wdata;
      else if (ee_load) ctrl_q[6:0] <= ee_ctrl[6:0];
      if (reg_wr && reg_addr == OFS_MASK) mask_q <= reg_wdata;
      if (reg_wr && reg_addr == OFS_TEMP_OFS) ofs_q <= reg_wdata;
      if (temp_valid) temp_q <= temp_raw + ofs_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  // No sample edge now or one cycle back, so no slope, tap or data-ready bit is being set
  sequence s_quiet;
    !sample_valid && !$past(sample_valid);
  endsequence

  a_reset_clear: assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00 && !int_out)
    else $error("outputs not cleared by reset");
  a_temp_value: assert property (s_rd(OFS_TEMP) |=> reg_rdata == $past(temp_q))
    else $error("temperature read wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr > OFS_ACC_LAST |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_drdy_raise: assert property (sample_valid && ctrl_q[CB_DRDY_EN] && mask_q[SB_DRDY] |=> int_out)
    else $error("data ready did not raise interrupt");
  a_drdy_release: assert property (s_rd(OFS_ACC_LAST) ##0 !sample_valid && mask_q == 8'h10 |=> !int_out)
    else $error("data ready not released by readout");
  a_status_clear: assert property (s_rd(OFS_STATUS) ##0 s_quiet ##0 (mask_q & 8'h0B) == 8'h00 |=> !int_out)
    else $error("status read did not clear interrupt");
  a_mask_gate: assert property (mask_q[4:0] == 5'h00 |-> !int_out)
    else $error("interrupt with all sources masked");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule

// ### sim/aei_host.sv
`timescale 1ns/100ps
module aei_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Idle write data is inverted so a stale value never passes for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // Read data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ### sim/aei_top_bench.sv
`timescale 1ns/100ps
module aei_top_bench;
  import aei_pkg::*;

  logic        clk, rst, sample_valid, temp_valid, ee_load, reg_wr, reg_rd, int_out;
  logic [7:0]  temp_raw, ee_ctrl, reg_addr, reg_wdata, reg_rdata, rd_v, t, o;
  aei_sample_s sample;
  logic [13:0] lx;
  int          mismatches, num_checks;

  aei_top dut_u (.clk, .rst, .sample_valid, .sample, .temp_valid, .temp_raw, .ee_load, .ee_ctrl,
                 .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .int_out);
  aei_host host_u (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------
  // Checking helpers
  // ------------------------------------------------
  task automatic close_out();
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string what);
    host_u.rd(a, rd_v);
    chk(what, rd_v, e);
  endtask

  task automatic ic(input logic e);
    chk("int_out", {7'h00, int_out}, {7'h00, e});
  endtask

  function automatic logic [7:0] exp_rst(input logic [7:0] a);
    if (a == OFS_LOW_DUR || a == OFS_HIGH_DUR) return RST_DUR;
    return (a == OFS_TAP_WIN) ? RST_WIN : 8'h00;
  endfunction

  // Random magnitude in [lo, hi) with random sign
  function automatic logic [13:0] rv(input int lo, input int hi);
    int m;
    m = lo + int'($urandom % (hi - lo));
    return ($urandom % 2) ? 14'(m) : 14'(-m);
  endfunction

  // Low and high results land two cycles after the sample; wait past that
  task automatic smp(input logic [13:0] x, input logic [13:0] y, input logic [13:0] z);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample.axis  <= {z, y, x};
    lx = x;
    @(posedge clk);
    sample_valid <= 1'b0;
    sample.axis  <= ~{z, y, x};
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    {sample_valid, temp_valid, ee_load} = 3'b000;
    sample = '0;
    temp_raw = 8'h00;
    ee_ctrl = 8'h00;
    mismatches = 0;
    num_checks = 0;
    rst = 1'b1;
    void'($urandom(32'h1A3F));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 13; a++)
      if (a != 10) rc(8'(a), exp_rst(8'(a)), "reset value");
    rc(8'h20, 8'h00, "unmapped");
    @(posedge clk);
    ee_load <= 1'b1;
    ee_ctrl <= 8'h81;
    @(posedge clk);
    ee_load <= 1'b0;
    rc(OFS_CTRL, 8'h01, "ctrl image");
    repeat (4) begin
      t = 8'($urandom);
      o = 8'($urandom);
      host_u.wr(OFS_TEMP_OFS, o);
      @(posedge clk);
      temp_valid <= 1'b1;
      temp_raw   <= t;
      @(posedge clk);
      temp_valid <= 1'b0;
      rc(OFS_TEMP, t + o, "temperature");
    end
    host_u.wr(OFS_CTRL, 8'h10);
    host_u.wr(OFS_MASK, 8'h10);
    fork
      host_u.rd(OFS_LOW_TH, rd_v);
      smp(rv(0, 8000), rv(0, 8000), rv(0, 8000));
    join
    chk("bus during sample", rd_v, RST_TH);
    ic(1'b1);
    rc(OFS_ACC_BASE, lx[7:0], "x low byte");
    host_u.rd(OFS_ACC_LAST, rd_v);
    ic(1'b0);
    host_u.wr(OFS_CTRL, 8'h01);
    host_u.wr(OFS_LOW_TH, 8'h28);
    host_u.wr(OFS_LOW_DUR, 8'h03);
    host_u.wr(OFS_LOW_HYST, 8'h14);
    host_u.wr(OFS_MASK, 8'h03);
    host_u.rd(OFS_STATUS, rd_v);
    smp(rv(0, 1280), rv(0, 1280), 14'h3B00);
    ic(1'b0);
    repeat (2) begin
      smp(rv(0, 1280), rv(0, 1280), rv(0, 1280));
      ic(1'b0);
    end
    smp(rv(0, 1280), rv(0, 1280), rv(0, 1280));
    ic(1'b1);
    rc(OFS_LEVEL, 8'h01, "low level");
    smp(rv(0, 1280), rv(1280, 1920), rv(0, 1280));
    ic(1'b1);
    smp(rv(0, 1280), 14'h0780, rv(0, 1280));
    host_u.rd(OFS_STATUS, rd_v);
    ic(1'b0);
    host_u.wr(OFS_CTRL, 8'h42);
    host_u.wr(OFS_HIGH_TH, 8'h64);
    host_u.wr(OFS_HIGH_HYST, 8'h0A);
    smp(14'h0000, 14'h0C80, 14'h0000);
    ic(1'b0);
    smp(14'h0000, 14'h337F, 14'h0000);
    ic(1'b1);
    smp(14'h0000, 14'h0000, 14'h0000);
    host_u.rd(OFS_LEVEL, rd_v);
    chk("high level", {7'h00, rd_v[1]}, 8'h01);
    host_u.wr(OFS_CTRL, 8'hC2);
    host_u.rd(OFS_STATUS, rd_v);
    ic(1'b0);
    host_u.wr(OFS_CTRL, 8'h0C);
    host_u.wr(OFS_SLOPE_TH, 8'h32);
    host_u.wr(OFS_MASK, 8'h04);
    smp(14'h0000, 14'h0000, 14'h0000);
    host_u.rd(OFS_STATUS, rd_v);
    smp(14'h0000, 14'h0000, 14'h0640);
    ic(1'b0);
    smp(14'h0000, 14'h0000, 14'h3FFF);
    ic(1'b1);
    smp(14'h0000, 14'h0000, 14'h3FFF);
    smp(14'h0000, 14'h0000, 14'h06A4);
    rc(OFS_STATUS, 8'h0C, "slope and tap");
    host_u.wr(OFS_CTRL, 8'h21);
    host_u.wr(OFS_MASK, 8'h01);
    repeat (2) smp(14'h07D0, 14'h07D0, 14'h07D0);
    smp(14'h3830, 14'h3830, 14'h3830);
    smp(14'h07D0, 14'h07D0, 14'h07D0);
    ic(1'b0);
    smp(14'h0000, 14'h0000, 14'h0000);
    ic(1'b1);
    close_out();
  end
endmodule

bind aei_top aei_top_asserts #(.DUR_W(DUR_W)) chk_u (.clk, .rst, .sample_valid, .temp_valid, .temp_raw,
  .ee_load, .ee_ctrl, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .int_out);
